// >>> rtl/pbg_bist_top.sv
`timescale 1ns/1ns
module pbg_bist_top (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_rx_pkt_done,
  input wire logic i_rx_crc_err,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last
);
  pbg_pkg::pbg_cfg_t cfg;
  pbg_pkg::pbg_state_t state;
  logic tx_en;
  logic clr_pulse;
  logic [10:0] byte_cnt;
  logic [pbg_pkg::GAP_W-1:0] gap_cnt;
  logic [pbg_pkg::BURST_W-1:0] pkt_cnt;
  logic [pbg_pkg::BURST_W-1:0] burst;
  logic [31:0] rx_count;
  logic [7:0] prbs_byte;
  logic wr_cfg1;
  logic wr_cfg2;
  logic st_idle;
  logic st_send;
  logic st_gap;
  logic [10:0] pkt_len;
  logic [pbg_pkg::GAP_W-1:0] gap_lim;
  logic last_byte;
  logic [pbg_pkg::BURST_W-1:0] sent_next;
  logic burst_done;
  logic rx_inc;
  logic [15:0] window;

  assign wr_cfg1 = i_reg_wr && (i_reg_addr == pbg_pkg::ADDR_CFG_ONE);
  assign wr_cfg2 = i_reg_wr && (i_reg_addr == pbg_pkg::ADDR_CFG_TWO);
  assign st_idle = (state == pbg_pkg::ST_IDLE);
  assign st_send = (state == pbg_pkg::ST_SEND);
  assign st_gap = (state == pbg_pkg::ST_GAP);

  assign pkt_len = cfg.len_long ? pbg_pkg::LEN_LONG : pbg_pkg::LEN_SHORT;
  assign gap_lim = cfg.ifg_long ? pbg_pkg::GAP_LONG : pbg_pkg::GAP_SHORT;
  assign last_byte = st_send && tx_en && (byte_cnt >= pkt_len - 11'h001);
  assign sent_next = pkt_cnt + 24'h000001;
  // A zero target never ends the stream
  assign burst_done = last_byte && (burst != '0) && (sent_next >= burst);

  // Configuration storage
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg <= pbg_pkg::CFG_RESET;
    end else begin
      if (wr_cfg1) begin
        cfg.cnt_type <= i_reg_wdata[pbg_pkg::C1_CNT_TYPE];
        cfg.len_long <= i_reg_wdata[pbg_pkg::C1_LEN];
        cfg.ifg_long <= i_reg_wdata[pbg_pkg::C1_IFG];
        cfg.pak_prbs <= i_reg_wdata[pbg_pkg::C1_PAK_TYPE];
        cfg.content <= i_reg_wdata[7:0];
      end
      if (wr_cfg2) begin
        cfg.rx_en <= i_reg_wdata[pbg_pkg::C2_RX_EN];
        cfg.cnt_sel <= i_reg_wdata[pbg_pkg::C2_CNT_SEL];
        cfg.pak_cnt <= i_reg_wdata[pbg_pkg::C2_PAK_CNT +: 3];
        cfg.led_sel <= i_reg_wdata[pbg_pkg::C2_LED_SEL];
      end
    end
  end

  // Software write wins over the self-clear
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_en <= 1'b0;
    end else if (wr_cfg1) begin
      tx_en <= i_reg_wdata[pbg_pkg::C1_TX_EN];
    end else if (burst_done) begin
      tx_en <= 1'b0;
    end
  end

  // Clear strobe, never stored as a readable bit
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= wr_cfg1 && i_reg_wdata[pbg_pkg::C1_CNT_CLR];
    end
  end

  // Generator sequencing
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= pbg_pkg::ST_IDLE;
      byte_cnt <= 11'h000;
      gap_cnt <= '0;
      pkt_cnt <= '0;
      burst <= '0;
    end else begin
      case (state)
        pbg_pkg::ST_IDLE: begin
          if (tx_en) begin
            state <= pbg_pkg::ST_SEND;
            byte_cnt <= 11'h000;
            pkt_cnt <= '0;
            burst <= pbg_pkg::burst_len(cfg.pak_cnt);
          end
        end
        pbg_pkg::ST_SEND: begin
          if (!tx_en) begin
            state <= pbg_pkg::ST_IDLE;
          end else if (last_byte) begin
            pkt_cnt <= sent_next;
            gap_cnt <= '0;
            state <= burst_done ? pbg_pkg::ST_IDLE : pbg_pkg::ST_GAP;
          end else begin
            byte_cnt <= byte_cnt + 11'h001;
          end
        end
        pbg_pkg::ST_GAP: begin
          if (!tx_en) begin
            state <= pbg_pkg::ST_IDLE;
          end else if (gap_cnt >= gap_lim - 9'h001) begin
            state <= pbg_pkg::ST_SEND;
            byte_cnt <= 11'h000;
          end else begin
            gap_cnt <= gap_cnt + 9'h001;
          end
        end
        default: begin
          state <= pbg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Transmit byte stream
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tx_valid <= 1'b0;
      o_tx_last <= 1'b0;
      o_tx_data <= 8'h00;
    end else begin
      o_tx_valid <= st_send && tx_en;
      o_tx_last <= last_byte;
      if (st_send && tx_en) begin
        o_tx_data <= cfg.pak_prbs ? prbs_byte : cfg.content;
      end else begin
        o_tx_data <= 8'h00;
      end
    end
  end

  pbg_prbs9 u_prbs (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_adv(st_send && tx_en),
    .o_byte(prbs_byte)
  );

  // Receive side only observes the receive strobes
  assign rx_inc = cfg.rx_en && (cfg.cnt_type ? i_rx_crc_err : i_rx_pkt_done);

  pbg_rx_counter #(
    .WIDTH(32)
  ) u_rx_cnt (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_clr(clr_pulse),
    .i_inc(rx_inc),
    .o_count(rx_count)
  );

  assign window = cfg.cnt_sel ? rx_count[31:16] : rx_count[15:0];

  // Read data follow the address one cycle later
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 16'h0000;
    end else begin
      case (i_reg_addr)
        pbg_pkg::ADDR_CNT_WIN: begin
          o_reg_rdata <= window;
        end
        pbg_pkg::ADDR_CFG_ONE: begin
          o_reg_rdata <= {cfg.cnt_type, 1'b0, cfg.len_long, cfg.ifg_long,
                          tx_en, cfg.pak_prbs, 2'b00, cfg.content};
        end
        pbg_pkg::ADDR_CFG_TWO: begin
          o_reg_rdata <= {cfg.rx_en, cfg.cnt_sel, cfg.pak_cnt, 10'h000, cfg.led_sel};
        end
        default: begin
          o_reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // Bytes already out in the current packet
  logic [10:0] out_cnt;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      out_cnt <= 11'h000;
    end else if (!o_tx_valid || o_tx_last) begin
      out_cnt <= 11'h000;
    end else begin
      out_cnt <= out_cnt + 11'h001;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  sequence s_cfg1_wr;
    i_reg_wr && (i_reg_addr == pbg_pkg::ADDR_CFG_ONE);
  endsequence

  sequence s_start;
    st_idle && tx_en;
  endsequence

  sequence s_short_gap;
    ($rose(st_gap) && !cfg.ifg_long) ##1 (tx_en && !cfg.ifg_long)[*5];
  endsequence

  chk_window_half: assert property (
    i_reg_addr == pbg_pkg::ADDR_CNT_WIN |=> o_reg_rdata ==
      ($past(cfg.cnt_sel) ? $past(rx_count[31:16]) : $past(rx_count[15:0])))
    else $error("counter window shows wrong half");

  chk_window_readonly: assert property (
    i_reg_wr && i_reg_addr == pbg_pkg::ADDR_CNT_WIN && !rx_inc && !clr_pulse
      |=> $stable(rx_count))
    else $error("write changed read-only counter");

  chk_count_kind: assert property (
    cfg.rx_en && !clr_pulse && (cfg.cnt_type ? i_rx_crc_err : i_rx_pkt_done)
      |=> rx_count == $past(rx_count) + 32'h00000001)
    else $error("selected receive event not counted");

  chk_count_ignore: assert property (
    cfg.rx_en && cfg.cnt_type && i_rx_pkt_done && !i_rx_crc_err && !clr_pulse
      |=> $stable(rx_count))
    else $error("packet counted in error mode");

  chk_clear_count: assert property (
    s_cfg1_wr ##0 i_reg_wdata[pbg_pkg::C1_CNT_CLR] |=> ##1 rx_count <= 32'h00000001)
    else $error("counter not cleared");

  chk_clear_selfclr: assert property (
    i_reg_addr == pbg_pkg::ADDR_CFG_ONE |=> !o_reg_rdata[pbg_pkg::C1_CNT_CLR])
    else $error("clear bit reads back set");

  chk_pkt_length: assert property (
    o_tx_last |-> out_cnt == $past(pkt_len) - 11'h001)
    else $error("packet length differs from setting");

  chk_gap_short: assert property (
    s_short_gap |-> st_send)
    else $error("short gap not five cycles");

  chk_gap_bound: assert property (
    st_gap |-> gap_cnt < pbg_pkg::GAP_LONG)
    else $error("gap counter overran long gap");

  chk_tx_start: assert property (
    s_start |=> st_send ##1 o_tx_valid)
    else $error("generator did not start");

  chk_tx_off: assert property (
    !tx_en |=> !o_tx_valid)
    else $error("byte sent while disabled");

  chk_burst_exact: assert property (
    burst_done |-> burst != '0 && sent_next == burst)
    else $error("burst ended at wrong count");

  chk_self_clear: assert property (
    burst_done && !wr_cfg1 |=> !tx_en && st_idle)
    else $error("enable did not self-clear");

  chk_burst_one: assert property (
    (s_start ##0 (cfg.pak_cnt == 3'h1 && !cfg.len_long))
      |-> ##60 tx_en ##1 !tx_en)
    else $error("single packet burst did not finish");

  chk_burst_code: assert property (
    s_start |=> burst == pbg_pkg::burst_len($past(cfg.pak_cnt)))
    else $error("burst size mismatches code");

  chk_rx_idle: assert property (
    !cfg.rx_en && !clr_pulse |=> $stable(rx_count))
    else $error("counter moved while disabled");

  chk_user_byte: assert property (
    o_tx_valid && !$past(cfg.pak_prbs) |-> o_tx_data == $past(cfg.content))
    else $error("user byte not sent");
endmodule : pbg_bist_top

// >>> shared/pbg_pkg.sv
package pbg_pkg;
// Overview of operation
// - Keep a 32-bit receive counter; show one 16-bit half, picked by select bit.
// - Counter window register is read-only, resets to zero, shows the count.
// - Counter type bit 15 one counts CRC errors, zero counts packets; resets zero.
// - Writing one to self-clearing bit 14 zeroes the counter (an event in the clear cycle leaves it at one); bit reads back zero.
// - Length bit picks 1514-byte packets when set, 60-byte when clear; resets zero.
// - Gap bit spaces packets 9.6 us when set, 0.096 us when clear (code rounds up to 5 cycles, 0.1 us); resets zero.
// - Setting enable bit 11 starts the generator; clear keeps it stopped.
// - Send exactly the configured packet count, or an unbroken stream if continuous.
// - Enable bit clears itself after the last packet; stays set when continuous.
// - Three-bit count code picks burst size: continuous, 1, 10, ... ten million.
// - Receive counter runs only while receive enable is one; traffic unaffected.
// - Packet type one sends pseudo-random bytes, zero sends the user byte.

  localparam logic [4:0] ADDR_CNT_WIN = 5'h18;
  localparam logic [4:0] ADDR_CFG_ONE = 5'h19;
  localparam logic [4:0] ADDR_CFG_TWO = 5'h1A;

  localparam int C1_CNT_TYPE = 15;
  localparam int C1_CNT_CLR = 14;
  localparam int C1_LEN = 13;
  localparam int C1_IFG = 12;
  localparam int C1_TX_EN = 11;
  localparam int C1_PAK_TYPE = 10;
  localparam int C2_RX_EN = 15;
  localparam int C2_CNT_SEL = 14;
  localparam int C2_PAK_CNT = 11;
  localparam int C2_LED_SEL = 0;

  localparam logic [10:0] LEN_LONG = 11'h5EA;
  localparam logic [10:0] LEN_SHORT = 11'h03C;

  localparam int CLK_PERIOD_NS = 20;
  localparam int IFG_LONG_NS = 9600;
  // 0.096 us
  localparam int IFG_SHORT_NS = 96;
  localparam int IFG_LONG_CYC = (IFG_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IFG_SHORT_CYC = (IFG_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W = 9;
  localparam logic [GAP_W-1:0] GAP_LONG = GAP_W'(IFG_LONG_CYC);
  localparam logic [GAP_W-1:0] GAP_SHORT = GAP_W'(IFG_SHORT_CYC);

  localparam int BURST_W = 24;
  localparam logic [8:0] PRBS_SEED = 9'h1FF;
  localparam logic [31:0] CNT_RESET = 32'h00000000;

  typedef struct packed {
    logic cnt_type;
    logic len_long;
    logic ifg_long;
    logic pak_prbs;
    logic [7:0] content;
    logic rx_en;
    logic cnt_sel;
    logic [2:0] pak_cnt;
    logic led_sel;
  } pbg_cfg_t;

  localparam pbg_cfg_t CFG_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_GAP = 3'b100
  } pbg_state_t;

  // Zero means continuous
  function automatic logic [BURST_W-1:0] burst_len(input logic [2:0] code);
    case (code)
      3'h1: burst_len = 24'h000001;
      3'h2: burst_len = 24'h00000A;
      3'h3: burst_len = 24'h000064;
      3'h4: burst_len = 24'h0003E8;
      3'h5: burst_len = 24'h002710;
      3'h6: burst_len = 24'h0F4240;
      3'h7: burst_len = 24'h989680;
      default: burst_len = 24'h000000;
    endcase
  endfunction : burst_len
endpackage : pbg_pkg

// >>> rtl/pbg_prbs9.sv
`timescale 1ns/1ns
module pbg_prbs9 (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_adv,
  output logic [7:0] o_byte
);
  logic [8:0] lfsr;
  logic [8:0] stage [0:8];

  assign stage[0] = lfsr;
  // Eight shifts of x^9 + x^5 + 1 per byte
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_shift
      assign stage[k+1] = {stage[k][7:0], stage[k][8] ^ stage[k][4]};
      assign o_byte[k] = stage[k][8];
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      lfsr <= pbg_pkg::PRBS_SEED;
    end else if (i_adv) begin
      lfsr <= stage[8];
    end
  end
endmodule : pbg_prbs9

// >>> rtl/pbg_rx_counter.sv
`timescale 1ns/1ns
module pbg_rx_counter #(
  parameter int WIDTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clr,
  input wire logic i_inc,
  output logic [WIDTH-1:0] o_count
);
  // An event in the clear cycle is kept as the first count
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= WIDTH'(pbg_pkg::CNT_RESET);
    end else if (i_clr) begin
      o_count <= i_inc ? WIDTH'(1) : '0;
    end else if (i_inc) begin
      o_count <= o_count + WIDTH'(1);
    end
  end
endmodule : pbg_rx_counter

// >>> verif/pbg_link_partner.sv
`timescale 1ns/1ns
module pbg_link_partner (
  input wire logic i_clk_sys,
  output logic o_pkt_done,
  output logic o_crc_err
);
  initial begin
    o_pkt_done = 1'b0;
    o_crc_err = 1'b0;
  end

  // Each call stands for exactly one clock cycle of receive events
  task automatic emit(input logic pkt, input logic crc);
    @(posedge i_clk_sys);
    #1;
    o_pkt_done = pkt;
    o_crc_err = crc;
  endtask : emit
endmodule : pbg_link_partner

// >>> verif/phy_bist_packet_gen_counter_tb_top.sv
`timescale 1ns/1ns
module phy_bist_packet_gen_counter_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic pkt;
  logic crc;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  int num_errors = 0;
  int tests_run = 0;
  int gap_cnt = 0;
  int np;
  int nc;
  int seed;
  logic [15:0] rd_q[$];
  logic [8:0] tx_q[$];
  int gap_q[$];
  event rd_ev;
  logic first_pkt = 1'b1;
  logic cont = 1'b0;
  logic [7:0] cont_byte = 8'h00;
  logic [7:0] ubyte;
  logic [8:0] lfsr_m = pbg_pkg::PRBS_SEED;
  logic [7:0] pbyte = 8'h00;
  logic cprbs = 1'b0;
  int gap_s = (96 + 19) / 20;
  int gap_l = 9600 / 20;

  always #10 clk = ~clk;

  pbg_bist_top dut_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_pkt_done(pkt),
    .i_rx_crc_err(crc), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last)
  );

  pbg_link_partner lp_u (.i_clk_sys(clk), .o_pkt_done(pkt), .o_crc_err(crc));

  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Reference pattern x^9 + x^5 + 1, first bit out lands in bit 0
  task automatic prbs_step();
    for (int b = 0; b < 8; b++) begin
      pbyte[b] = lfsr_m[8];
      lfsr_m = {lfsr_m[7:0], lfsr_m[8] ^ lfsr_m[4]};
    end
  endtask : prbs_step

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr = 1'b1;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1;
    addr = a;
    rd_q.push_back(exp);
    @(posedge clk);
    #1;
    ->rd_ev;
  endtask : rd_reg

  task automatic wait_drain(input int limit);
    for (int i = 0; i < limit && tx_q.size() > 0; i++) @(posedge clk);
    if (tx_q.size() > 0) begin
      num_errors++;
      print_verdict();
    end
    repeat (3) @(posedge clk);
  endtask : wait_drain

  task automatic tx_burst(input logic [2:0] code, input int npk, input logic len,
                          input logic ifg, input logic [7:0] c);
    int n;
    n = len ? 1514 : 60;
    first_pkt = 1'b1;
    for (int p = 0; p < npk; p++) begin
      if (p > 0) gap_q.push_back(ifg ? gap_l : gap_s);
      for (int b = 0; b < n; b++) tx_q.push_back({b == n - 1, c});
    end
    wr_reg(pbg_pkg::ADDR_CFG_TWO, {2'b00, code, 11'h000});
    wr_reg(pbg_pkg::ADDR_CFG_ONE, {2'b00, len, ifg, 1'b1, 3'b000, c});
    wait_drain(25000);
    rd_reg(pbg_pkg::ADDR_CFG_ONE, {2'b00, len, ifg, 1'b0, 3'b000, c});
  endtask : tx_burst

  always @(rd_ev) check(rdata, rd_q.pop_front());

  // Outputs are sampled at the edge, so the values seen are last cycle's
  always @(posedge clk) begin
    if (nrst !== 1'b1) begin
      gap_cnt = 0;
    end else if (tx_valid === 1'b1) begin
      prbs_step();
      if (gap_cnt > 0) begin
        if (first_pkt) first_pkt = 1'b0;
        else if (gap_q.size() > 0) check(16'(gap_cnt), 16'(gap_q.pop_front()));
      end
      gap_cnt = 0;
      if (tx_q.size() > 0) check({7'h00, tx_last, tx_data}, {7'h00, tx_q.pop_front()});
      else if (cont) check({8'h00, tx_data}, {8'h00, cprbs ? pbyte : cont_byte});
      else check(16'h0001, 16'h0000);
    end else begin
      gap_cnt++;
      check({7'h00, tx_last, tx_data}, 16'h0000);
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    seed = $urandom(95);
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'h0000);
    rd_reg(pbg_pkg::ADDR_CFG_ONE, 16'h0000);
    rd_reg(pbg_pkg::ADDR_CFG_TWO, 16'h0000);
    wr_reg(pbg_pkg::ADDR_CNT_WIN, 16'hFFFF);
    wr_reg(5'h1B, 16'hFFFF);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'h0000);
    rd_reg(5'h1B, 16'h0000);
    // Packets counted, errors ignored
    wr_reg(pbg_pkg::ADDR_CFG_TWO, 16'h8000);
    np = 0;
    for (int i = 0; i < 40; i++) begin
      lp_u.emit(1'($urandom % 2), 1'($urandom % 2));
      np += int'(pkt);
    end
    lp_u.emit(1'b0, 1'b0);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'(np));
    wr_reg(pbg_pkg::ADDR_CFG_TWO, 16'hC000);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'h0000);
    wr_reg(pbg_pkg::ADDR_CFG_ONE, 16'h4000);
    wr_reg(pbg_pkg::ADDR_CFG_TWO, 16'h8000);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'h0000);
    // Errors counted, then receive disabled
    wr_reg(pbg_pkg::ADDR_CFG_ONE, 16'h8000);
    nc = 0;
    for (int i = 0; i < 40; i++) begin
      lp_u.emit(1'($urandom % 2), 1'($urandom % 2));
      nc += int'(crc);
    end
    lp_u.emit(1'b0, 1'b0);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'(nc));
    wr_reg(pbg_pkg::ADDR_CFG_TWO, 16'h0000);
    for (int i = 0; i < 10; i++) lp_u.emit(1'b1, 1'b1);
    lp_u.emit(1'b0, 1'b0);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'(nc));
    wr_reg(pbg_pkg::ADDR_CFG_ONE, 16'hC000);
    rd_reg(pbg_pkg::ADDR_CNT_WIN, 16'h0000);
    rd_reg(pbg_pkg::ADDR_CFG_ONE, 16'h8000);
    // Finite bursts
    tx_burst(3'h1, 1, 1'b0, 1'b0, 8'hA5);
    ubyte = 8'($urandom);
    tx_burst(3'h2, 10, 1'b1, 1'b1, ubyte);
    // Remaining codes run on and must keep the enable bit set until aborted
    for (int k = 0; k < 8; k++) begin
      if (k == 1 || k == 2) continue;
      cont_byte = 8'($urandom);
      cprbs = (k % 2 == 1);
      cont = 1'b1;
      wr_reg(pbg_pkg::ADDR_CFG_TWO, {2'b00, 3'(k), 11'h000});
      wr_reg(pbg_pkg::ADDR_CFG_ONE, {5'b00001, cprbs, 2'b00, cont_byte});
      repeat (200) @(posedge clk);
      rd_reg(pbg_pkg::ADDR_CFG_ONE, {5'b00001, cprbs, 2'b00, cont_byte});
      wr_reg(pbg_pkg::ADDR_CFG_ONE, {8'h00, cont_byte});
      repeat (5) @(posedge clk);
      cont = 1'b0;
    end
    repeat (10) @(posedge clk);
    print_verdict();
  end
endmodule : phy_bist_packet_gen_counter_tb_top
